// *** design/dsp_multiply_saturate_unit.sv ***
`timescale 1ns/10ps
// Overview of operation
// [RL1] Long multiply writes full 64-bit signed product
// [RL2] Word times selected signed halfword of second
// [RL3] Word-by-half result is product bits 47:16
// [RL4] Bottom picks bits 15:0, top 31:16
// [RL5] Dual multiply-subtract: low product minus high
// [RL6] Exchange variant rotates second operand sixteen bits
// [RL7] Multiplies never touch saturation or status flags
// [RL8] Word saturate clamps to 1..32 bit range
// [RL9] Pre-shift: left 0..31 or arithmetic right
// [RL10] Shifter ignores carry; carry never updated
// [RL11] Clamping sets sticky saturation flag, else unchanged
// [RL12] Halfword saturate clamps each half, 1..16 bits
// [RL13] Either clamped half sets sticky saturation flag
// [RL14] Decoder avoids registers 13 and 15 there
// [RL15] Low half sum, high half difference, truncated
// [RL16] Greater-equal pairs follow sign of sum, difference
// [RL17] Failed condition writes nothing, keeps all flags
module dsp_multiply_saturate_unit
  import dsp_unit_pkg::*;
#(
  parameter int unsigned ADDR_W = ADDR_W_DEFAULT
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // Request from decode stage
  input wire logic req_valid,
  output logic req_ready,
  input wire op_t req_op,
  input wire logic req_cond_pass,
  input wire logic [31:0] first_operand_register,
  input wire logic [31:0] second_operand_register,
  input wire logic req_shift_arith,
  input wire logic [4:0] req_shift_amount,
  input wire logic [4:0] req_sat_width_m1,
  // Result to register file
  output logic res_valid,
  output logic res_write,
  output logic res_write_hi,
  output logic [31:0] res_lo,
  output logic [31:0] res_hi,
  // Flags
  output logic sticky_saturation_flag,
  output logic [3:0] greater_equal_flags,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must lie between 8 and 32");
  end

  // ****************************************
  // Operand selection and multipliers
  // ****************************************
  logic [15:0] mul_half;
  logic [31:0] second_swapped;
  logic signed [63:0] prod_long;
  logic signed [47:0] prod_word_half;
  logic signed [31:0] prod_pair_lo;
  logic signed [31:0] prod_pair_hi;
  logic [31:0] dual_diff;

  assign mul_half = (req_op == word_by_high_half_multiply) ?
    second_operand_register[31:16] : second_operand_register[15:0]; // RL4
  assign prod_long = $signed(first_operand_register) *
    $signed(second_operand_register); // RL1
  assign prod_word_half = $signed(first_operand_register) * $signed(mul_half); // RL2
  assign second_swapped = (req_op == dual_multiply_subtract_exchanged) ?
    {second_operand_register[15:0], second_operand_register[31:16]} :
    second_operand_register; // RL6
  assign prod_pair_lo = $signed(first_operand_register[15:0]) *
    $signed(second_swapped[15:0]); // RL5
  assign prod_pair_hi = $signed(first_operand_register[31:16]) *
    $signed(second_swapped[31:16]); // RL5
  // Both products lie within plus or minus 2^30, so the 32-bit difference is exact
  assign dual_diff = prod_pair_lo - prod_pair_hi; // RL5

  // ****************************************
  // Word saturation
  // ****************************************
  logic [31:0] shifted;
  logic [31:0] word_over;
  logic [31:0] word_min;
  logic word_fits;
  logic [31:0] word_result;

  // The carry flag is not an input here at all; shifted-out bits are lost
  assign shifted = req_shift_arith ?
    32'($signed(first_operand_register) >>> req_shift_amount) :
    32'(first_operand_register << req_shift_amount); // RL9 RL10
  assign word_over = 32'($signed(shifted) >>> req_sat_width_m1);
  assign word_fits = (word_over == 32'h00000000) || (word_over == 32'hffffffff);
  assign word_min = 32'(32'hffffffff << req_sat_width_m1);
  assign word_result = word_fits ? shifted :
    (shifted[31] ? word_min : ~word_min); // RL8

  // ****************************************
  // Dual halfword saturation
  // ****************************************
  logic [31:0] half_result;
  logic [1:0] half_sat;

  for (genvar h = 0; h < 2; h++) begin : g_half
    logic [15:0] val;
    logic [15:0] over;
    logic [15:0] hmin;
    logic fits;
    assign val = first_operand_register[16*h +: 16];
    assign over = 16'($signed(val) >>> req_sat_width_m1[3:0]);
    assign fits = (over == 16'h0000) || (over == 16'hffff);
    assign hmin = 16'(16'hffff << req_sat_width_m1[3:0]);
    assign half_sat[h] = ~fits;
    assign half_result[16*h +: 16] = fits ? val : (val[15] ? hmin : ~hmin); // RL12
  end

  // ****************************************
  // Halfword subtract-add with exchange
  // ****************************************
  logic [16:0] sa_sum;
  logic [16:0] sa_diff;
  logic [3:0] sa_ge;

  assign sa_sum = {first_operand_register[15], first_operand_register[15:0]} +
    {second_operand_register[31], second_operand_register[31:16]}; // RL15
  assign sa_diff = {first_operand_register[31], first_operand_register[31:16]} -
    {second_operand_register[15], second_operand_register[15:0]}; // RL15
  assign sa_ge = {{2{~sa_diff[16]}}, {2{~sa_sum[16]}}}; // RL16

  // ****************************************
  // Result selection
  // ****************************************
  logic [31:0] sel_lo;
  logic [31:0] sel_hi;
  logic sel_sat;

  always_comb begin
    sel_lo = 32'h00000000;
    sel_hi = 32'h00000000;
    sel_sat = 1'b0;
    case (req_op)
      long_multiply: begin
        sel_lo = prod_long[31:0]; // RL1
        sel_hi = prod_long[63:32]; // RL1
      end
      word_by_low_half_multiply, word_by_high_half_multiply: begin
        sel_lo = prod_word_half[47:16]; // RL3
      end
      dual_multiply_subtract, dual_multiply_subtract_exchanged: begin
        sel_lo = dual_diff;
      end
      signed_word_saturate: begin
        sel_lo = word_result;
        sel_sat = ~word_fits; // RL11
      end
      signed_dual_half_saturate: begin
        sel_lo = half_result;
        sel_sat = |half_sat; // RL13
      end
      half_subtract_add_exchange: begin
        sel_lo = {sa_diff[15:0], sa_sum[15:0]}; // RL15
      end
    endcase
  end

  // ****************************************
  // Execution and flag state
  // ****************************************
  logic ctrl_enable_r;
  logic sat_flag_r;
  logic [3:0] ge_r;
  logic res_valid_r;
  logic res_write_r;
  logic res_write_hi_r;
  logic [31:0] res_lo_r;
  logic [31:0] res_hi_r;
  logic exec;
  logic commit;
  logic sat_event;
  logic sat_clear;
  logic sat_flag_nxt;
  logic [3:0] ge_nxt;

  assign exec = req_valid & ctrl_enable_r;
  assign commit = exec & req_cond_pass; // RL17
  // Only the two saturating operations may raise the flag
  assign sat_event = commit & sel_sat; // RL7 RL11
  // A saturation in the same cycle as a software clear wins
  assign sat_flag_nxt = sat_event | (sat_flag_r & ~sat_clear); // RL11
  assign ge_nxt = (commit && req_op == half_subtract_add_exchange) ? sa_ge : ge_r; // RL16 RL17

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sat_flag_r <= SAT_FLAG_RESET;
      ge_r <= GE_FLAGS_RESET;
      res_valid_r <= 1'b0;
      res_write_r <= 1'b0;
      res_write_hi_r <= 1'b0;
      res_lo_r <= 32'h00000000;
      res_hi_r <= 32'h00000000;
    end else if (ce) begin
      sat_flag_r <= sat_flag_nxt;
      ge_r <= ge_nxt;
      res_valid_r <= exec;
      res_write_r <= commit; // RL17
      res_write_hi_r <= commit && req_op == long_multiply; // RL1
      if (exec) begin
        res_lo_r <= sel_lo;
        res_hi_r <= sel_hi;
      end
    end
  end

  // ****************************************
  // AXI4-Lite write path
  // ****************************************
  logic aw_full_r;
  logic w_full_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic aw_take;
  logic w_take;
  logic do_write;
  logic aw_full_nxt;
  logic w_full_nxt;
  logic bvalid_nxt;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ctrl;
  logic wr_status;

  assign aw_take = s_axi_awvalid & awready_r;
  assign w_take = s_axi_wvalid & wready_r;
  assign do_write = (aw_full_r | aw_take) & (w_full_r | w_take) & ~bvalid_r;
  assign aw_full_nxt = (aw_full_r | aw_take) & ~do_write;
  assign w_full_nxt = (w_full_r | w_take) & ~do_write;
  assign bvalid_nxt = do_write | (bvalid_r & ~s_axi_bready);
  assign wr_addr = aw_full_r ? aw_addr_r : s_axi_awaddr;
  assign wr_data = w_full_r ? w_data_r : s_axi_wdata;
  assign wr_strb = w_full_r ? w_strb_r : s_axi_wstrb;
  assign wr_ctrl = do_write && wr_addr == ADDR_W'(CTRL_OFFSET);
  assign wr_status = do_write && wr_addr == ADDR_W'(STATUS_OFFSET);
  // Write one to clear; the greater-equal bits are read only
  assign sat_clear = wr_status & wr_strb[0] & wr_data[STATUS_SAT_BIT];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (ce) begin
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      awready_r <= ~aw_full_nxt & ~bvalid_nxt;
      wready_r <= ~w_full_nxt & ~bvalid_nxt;
      bvalid_r <= bvalid_nxt;
      if (do_write) begin
        bresp_r <= (wr_ctrl || wr_status) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_addr_r <= '0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      ctrl_enable_r <= CTRL_ENABLE_RESET;
    end else if (ce) begin
      if (aw_take) begin
        aw_addr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_ctrl && wr_strb[0]) begin
        ctrl_enable_r <= wr_data[CTRL_ENABLE_BIT];
      end
    end
  end

  // ****************************************
  // AXI4-Lite read path
  // ****************************************
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic ar_take;
  logic rvalid_nxt;
  logic rd_ctrl;
  logic rd_status;
  logic [31:0] rd_word;

  assign ar_take = s_axi_arvalid & arready_r;
  assign rvalid_nxt = ar_take | (rvalid_r & ~s_axi_rready);
  assign rd_ctrl = s_axi_araddr == ADDR_W'(CTRL_OFFSET);
  assign rd_status = s_axi_araddr == ADDR_W'(STATUS_OFFSET);
  assign rd_word = rd_ctrl ? 32'(ctrl_enable_r) << CTRL_ENABLE_BIT :
    rd_status ? (32'(ge_r) << STATUS_GE_LSB) | (32'(sat_flag_r) << STATUS_SAT_BIT) : 32'h00000000;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= RESP_OKAY;
    end else if (ce) begin
      arready_r <= ~rvalid_nxt;
      rvalid_r <= rvalid_nxt;
      if (ar_take) begin
        rdata_r <= rd_word;
        rresp_r <= (rd_ctrl || rd_status) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign req_ready = ctrl_enable_r;
  assign res_valid = res_valid_r;
  assign res_write = res_write_r;
  assign res_write_hi = res_write_hi_r;
  assign res_lo = res_lo_r;
  assign res_hi = res_hi_r;
  assign sticky_saturation_flag = sat_flag_r;
  assign greater_equal_flags = ge_r;
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

endmodule

// *** design/dsp_unit_pkg.sv ***
package dsp_unit_pkg;

  // ****************************************
  // Register map and fields
  // ****************************************
  localparam int unsigned ADDR_W_DEFAULT = 8;
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned STATUS_SAT_BIT = 0;
  localparam int unsigned STATUS_GE_LSB = 1;
  localparam logic CTRL_ENABLE_RESET = 1'b1;
  localparam logic SAT_FLAG_RESET = 1'b0;
  localparam logic [3:0] GE_FLAGS_RESET = 4'h0;

  // ****************************************
  // Bus answers
  // ****************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // Datapath constants
  // ****************************************
  localparam int unsigned WORD_W = 32;
  localparam int unsigned HALF_W = 16;
  localparam logic [3:0] GE_ALL_SET = 4'h3;

  // ****************************************
  // Operations
  // ****************************************
  typedef enum logic [2:0] {
    long_multiply = 3'b000,
    word_by_low_half_multiply = 3'b001,
    word_by_high_half_multiply = 3'b010,
    dual_multiply_subtract = 3'b011,
    dual_multiply_subtract_exchanged = 3'b100,
    signed_word_saturate = 3'b101,
    signed_dual_half_saturate = 3'b110,
    half_subtract_add_exchange = 3'b111
  } op_t;

endpackage

// *** tb/dsp_unit_chk.sv ***
`timescale 1ns/10ps
module dsp_unit_chk
  import dsp_unit_pkg::*;
(
  // Watched ports
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire op_t req_op,
  input wire logic req_cond_pass,
  input wire logic [31:0] first_operand_register,
  input wire logic [31:0] second_operand_register,
  input wire logic res_valid,
  input wire logic res_write,
  input wire logic res_write_hi,
  input wire logic [31:0] res_lo,
  input wire logic [31:0] res_hi,
  input wire logic sticky_saturation_flag,
  input wire logic [3:0] greater_equal_flags,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid
);
  wire logic [31:0] a = first_operand_register;
  wire logic [31:0] b = second_operand_register;
  wire logic take = ce && req_valid && req_ready;
  wire logic ok = take && req_cond_pass;
  // A software clear may move the sticky flag while either write half is on the bus
  wire logic bus_quiet = !s_axi_awvalid && !s_axi_wvalid;
  wire logic [4:0] flg = {sticky_saturation_flag, greater_equal_flags};
  wire logic signed [63:0] prod = $signed(a) * $signed(b);
  wire logic signed [16:0] sum = $signed(a[15:0]) + $signed(b[31:16]);
  wire logic signed [16:0] dif = $signed(a[31:16]) - $signed(b[15:0]);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_answer_next: assert property (take |=> res_valid) else $error("no result after take");
  a_idle_quiet: assert property (ce && !take |=> !res_valid) else $error("result without take");
  a_fail_quiet: assert property (take && !req_cond_pass && bus_quiet |=>
    !res_write && !res_write_hi && $stable(flg)) else $error("failed condition had effect");
  a_long_product: assert property (ok && req_op == long_multiply |=>
    res_write_hi && {res_hi, res_lo} == $past(prod)) else $error("long product wrong");
  a_hi_long_only: assert property (take && req_op != long_multiply |=> !res_write_hi)
    else $error("high write outside long multiply");
  a_mul_flags_kept: assert property (take && bus_quiet &&
    req_op inside {[word_by_low_half_multiply:dual_multiply_subtract_exchanged]} |=>
    $stable(flg)) else $error("multiply changed flags");
  a_sum_diff_halves: assert property (ok && req_op == half_subtract_add_exchange |=>
    res_lo == {$past(dif[15:0]), $past(sum[15:0])}) else $error("sum or difference wrong");
  a_ge_signs: assert property (ok && req_op == half_subtract_add_exchange |=>
    greater_equal_flags == {{2{!$past(dif[16])}}, {2{!$past(sum[16])}}})
    else $error("greater-equal flags wrong");
  a_sticky_kept: assert property (ce && !take && bus_quiet |=>
    $stable(sticky_saturation_flag)) else $error("sticky flag moved without cause");
  c_long: cover property (ok && req_op == long_multiply);
  c_fail: cover property (take && !req_cond_pass);
  c_sat: cover property ($rose(sticky_saturation_flag));
endmodule

bind dsp_multiply_saturate_unit dsp_unit_chk dsp_unit_chk_i (.*);

// *** tb/regfile_model.sv ***
`timescale 1ns/10ps
// ****
// Register file side of the result port
// ****
module regfile_model (
  // Result port
  input wire logic clk,
  input wire logic res_valid,
  input wire logic res_write,
  input wire logic res_write_hi,
  // Write counts
  output int writes,
  output int hi_writes
);
  int lo_count_r = 0;
  int hi_count_r = 0;
  // No register index reaches the unit; keeping 13 and 15 out is the decoder's job
  always @(posedge clk) begin
    if (res_valid && res_write) lo_count_r <= lo_count_r + 1;
    if (res_valid && res_write_hi) hi_count_r <= hi_count_r + 1;
  end
  assign writes = lo_count_r;
  assign hi_writes = hi_count_r;
endmodule

// *** tb/test_dsp_multiply_saturate_unit.sv ***
`timescale 1ns/10ps
module test_dsp_multiply_saturate_unit
  import dsp_unit_pkg::*;
;
  logic clk, reset_n, ce, req_valid, req_ready, req_cond_pass, req_shift_arith;
  logic res_valid, res_write, res_write_hi, sticky_saturation_flag;
  logic [4:0] req_shift_amount, req_sat_width_m1;
  logic [31:0] first_operand_register, second_operand_register, res_lo, res_hi;
  logic [3:0] greater_equal_flags, s_axi_wstrb;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  op_t req_op;
  int num_errors = 0, num_checks = 0, writes, hi_writes;
  dsp_multiply_saturate_unit dsp_multiply_saturate_unit_i (.*);
  regfile_model regfile_model_i (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic limit(input int n);
    if (n >= 20) begin
      num_errors++;
      $display("mismatch at %0t: wait ran out", $time);
      final_report();
    end
  endtask
  // s packs arithmetic-shift flag, shift count and width minus one
  task automatic req(input op_t op, input logic [31:0] a, b, input logic [10:0] s, input logic c);
    int n;
    @(posedge clk);
    req_op <= op;
    first_operand_register <= a;
    second_operand_register <= b;
    {req_shift_arith, req_shift_amount, req_sat_width_m1} <= s;
    req_cond_pass <= c;
    req_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 20);
    limit(n);
    req_valid <= 1'b0;
    #1;
    check(64'(res_valid), 64'h1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rsp);
    int n;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'h1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 20);
    limit(n);
    s_axi_bready <= 1'b0;
    check(64'(s_axi_bresp), 64'(rsp));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rsp);
    int n;
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 20);
    limit(n);
    s_axi_rready <= 1'b0;
    check(64'({s_axi_rresp, s_axi_rdata}), 64'({rsp, d}));
  endtask
  task automatic t_regs();
    rd(CTRL_OFFSET, 32'h1, RESP_OKAY);
    rd(STATUS_OFFSET, 32'h0, RESP_OKAY);
    rd(8'h08, 32'h0, RESP_SLVERR);
    wr(8'h08, 32'h0, RESP_SLVERR);
    wr(CTRL_OFFSET, 32'h0, RESP_OKAY);
    // Disabled unit must refuse and stay silent
    @(posedge clk);
    req_valid <= 1'b1;
    repeat (3) @(posedge clk);
    req_valid <= 1'b0;
    #1;
    check(64'({req_ready, res_valid}), 64'h0);
    wr(CTRL_OFFSET, 32'h1, RESP_OKAY);
    rd(CTRL_OFFSET, 32'h1, RESP_OKAY);
    $display("register test done");
  endtask
  task automatic t_mul();
    int w;
    int h;
    w = writes;
    h = hi_writes;
    req(long_multiply, 32'hfffffffe, 32'h00030000, 11'h0, 1'b1);
    check({res_hi, res_lo}, 64'hfffffffffffa0000);
    check(64'({res_write, res_write_hi}), 64'h3);
    req(word_by_low_half_multiply, 32'h00010001, 32'h80000003, 11'h0, 1'b1);
    check(64'(res_lo), 64'h3);
    req(word_by_high_half_multiply, 32'h00010001, 32'h80000003, 11'h0, 1'b1);
    check(64'(res_lo), 64'hffff7fff);
    req(dual_multiply_subtract, 32'hfffe0003, 32'h00050007, 11'h0, 1'b1);
    check(64'(res_lo), 64'h1f);
    req(dual_multiply_subtract_exchanged, 32'hfffe0003, 32'h00050007, 11'h0, 1'b1);
    check(64'(res_lo), 64'h1d);
    @(posedge clk);
    #1;
    check(64'(writes), 64'(w + 5));
    check(64'(hi_writes), 64'(h + 1));
    $display("multiply test done");
  endtask
  task automatic t_sat();
    wr(STATUS_OFFSET, 32'h1, RESP_OKAY);
    req(signed_word_saturate, 32'h7f, 32'h0, 11'h007, 1'b1);
    check(64'({sticky_saturation_flag, res_lo}), 64'h7f);
    req(signed_word_saturate, 32'h100, 32'h0, {1'b0, 5'd4, 5'd7}, 1'b1);
    check(64'({sticky_saturation_flag, res_lo}), 64'h10000007f);
    wr(STATUS_OFFSET, 32'h1, RESP_OKAY);
    rd(STATUS_OFFSET, 32'h0, RESP_OKAY);
    req(signed_word_saturate, 32'hfffff000, 32'h0, {1'b1, 5'd4, 5'd7}, 1'b1);
    check(64'({sticky_saturation_flag, res_lo}), 64'h1ffffff80);
    wr(STATUS_OFFSET, 32'h1, RESP_OKAY);
    req(signed_dual_half_saturate, 32'h0010fff0, 32'h0, 11'h004, 1'b1);
    check(64'({sticky_saturation_flag, res_lo}), 64'h1000ffff0);
    wr(STATUS_OFFSET, 32'h1, RESP_OKAY);
    req(signed_dual_half_saturate, 32'h0000ffef, 32'h0, 11'h004, 1'b1);
    check(64'({sticky_saturation_flag, res_lo}), 64'h10000fff0);
    $display("saturate test done");
  endtask
  task automatic t_half_subtract_add_exchange();
    req(half_subtract_add_exchange, 32'h00017fff, 32'h00020001, 11'h0, 1'b1);
    check(64'({greater_equal_flags, res_lo}), 64'hf00008001);
    req(half_subtract_add_exchange, 32'h0, 32'h00010001, 11'h0, 1'b1);
    check(64'({greater_equal_flags, res_lo}), 64'h3ffff0001);
    rd(STATUS_OFFSET, 32'h7, RESP_OKAY);
    $display("subtract-add test done");
  endtask
  task automatic t_cond();
    int w;
    wr(STATUS_OFFSET, 32'h1, RESP_OKAY);
    w = writes;
    req(signed_dual_half_saturate, 32'h0010fff0, 32'h0, 11'h004, 1'b0);
    check(64'({res_write, res_write_hi, sticky_saturation_flag}), 64'h0);
    req(half_subtract_add_exchange, 32'h0, 32'h0, 11'h0, 1'b0);
    check(64'(greater_equal_flags), 64'h3);
    @(posedge clk);
    #1;
    check(64'(writes), 64'(w));
    $display("condition test done");
  endtask
  // A saturating request offered while the clock enable is low must leave no trace
  task automatic t_freeze();
    @(posedge clk);
    ce <= 1'b0;
    req_op <= signed_word_saturate;
    first_operand_register <= 32'h00000100;
    {req_shift_arith, req_shift_amount, req_sat_width_m1} <= {1'b0, 5'd4, 5'd7};
    req_cond_pass <= 1'b1;
    req_valid <= 1'b1;
    repeat (2) @(posedge clk);
    ce <= 1'b1;
    req_valid <= 1'b0;
    @(posedge clk);
    #1;
    check(64'({res_valid, sticky_saturation_flag}), 64'h0);
    $display("clock enable test done");
  endtask
  initial begin
    reset_n = 1'b0;
    ce = 1'b1;
    req_op = long_multiply;
    {req_valid, req_cond_pass, req_shift_arith, req_shift_amount, req_sat_width_m1} = '0;
    {first_operand_register, second_operand_register} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_mul();
    t_sat();
    t_half_subtract_add_exchange();
    t_cond();
    t_freeze();
    final_report();
  end
endmodule
